// *** common/asl_map.svh ***
`ifndef ASL_MAP_SVH
`define ASL_MAP_SVH

// Opcode bytes: one-byte forms, wide immediate lead byte and prefixes
`define ASL_OP_ADC_IND      8'h3E
`define ASL_OP_ADS_IND      8'h3F
`define ASL_OP_AND_IND      8'h39
`define ASL_OP_ADS_WIDE_IMM 8'hC9
`define ASL_OP_PFX_PAIR     8'hDC
`define ASL_OP_PFX_AND_IMM  8'hDD
// Upper nibble of the short immediate add-skip form
`define ASL_HI_ADS_IMM      4'hA
// Upper nibble of the second byte of the immediate AND form
`define ASL_HI_AND_IMM      4'h1
// Second byte of prefixed pair forms: bits 7:3, pair select in 2:1, bit 0 zero
`define ASL_SB_ADS_SRC      5'h13
`define ASL_SB_ADS_DST      5'h12
`define ASL_SB_AND_SRC      5'h03
`define ASL_SB_AND_DST      5'h02
// Reset values
`define ASL_RST_NIBBLE      4'h0
`define ASL_RST_BYTE        8'h00

`endif

// *** common/asl_pkg.sv ***
package asl_pkg;

  typedef enum logic [1:0] {
    ASL_ST_FIRST  = 2'b00,
    ASL_ST_SECOND = 2'b01,
    ASL_ST_DROP   = 2'b10
  } asl_state_e;

  typedef enum logic [3:0] {
    ASL_OPN_NONE     = 4'h0,
    ASL_OPN_ADS_WIMM = 4'h1,
    ASL_OPN_ADS_SRC  = 4'h2,
    ASL_OPN_ADS_DST  = 4'h3,
    ASL_OPN_AND_IMM  = 4'h4,
    ASL_OPN_AND_SRC  = 4'h5,
    ASL_OPN_AND_DST  = 4'h6
  } asl_pend_e;

  typedef enum logic [2:0] {
    ASL_FN_ADD  = 3'h0,
    ASL_FN_ADC  = 3'h1,
    ASL_FN_AND  = 3'h2,
    ASL_FN_PASS = 3'h3
  } asl_fn_e;

endpackage : asl_pkg

// *** rtl/asl_alu.sv ***
`timescale 1ns/1ps
`include "asl_map.svh"

// Combinational 8-bit operator; 4-bit operations use the low nibble
module asl_alu (
  input  wire logic           [7:0] opa,
  input  wire logic           [7:0] opb,
  input  wire logic                 cin,
  input  wire logic                 narrow,
  input  wire asl_pkg::asl_fn_e     fn,
  output logic                [7:0] res,
  output logic                      cout
);

  logic [8:0] sum8;
  logic [4:0] sum4;

  always_comb
  begin
    sum8 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
    sum4 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    res  = `ASL_RST_BYTE;
    cout = 1'b0;
    case (fn)
      asl_pkg::ASL_FN_ADD, asl_pkg::ASL_FN_ADC:
      begin
        if (narrow)
        begin
          res  = {4'h0, sum4[3:0]};
          cout = sum4[4];
        end
        else
        begin
          res  = sum8[7:0];
          cout = sum8[8];
        end
      end
      asl_pkg::ASL_FN_AND:
      begin
        res = opa & opb;
      end
      asl_pkg::ASL_FN_PASS:
      begin
        res = opa;
      end
      default:
      begin
        res  = `ASL_RST_BYTE;
        cout = 1'b0;
      end
    endcase
  end

endmodule : asl_alu

// *** rtl/asl_exec.sv ***
`timescale 1ns/1ps
`include "asl_map.svh"

// How it works
// - Byte 1010dddd adds a 4-bit immediate to A; one cycle plus skip.
// - Byte C9h then 8-bit immediate adds into the wide accumulator; two cycles plus skip.
// - Byte 3Fh adds memory nibble at pointer pair to A; one cycle plus skip.
// - Prefix DCh, 10011rr0 adds selected pair into wide accumulator; two cycles plus skip.
// - Prefix DCh, 10010rr0 adds wide accumulator into selected pair; two cycles plus skip.
// - Add-skip writes sum to destination, keeps source; overflow raises skip.
// - Add-skip never changes the carry flag.
// - Indirect add-with-carry then short immediate add-skip: carry skips that add-skip.
// - Short immediate add-skip right after indirect add-with-carry never skips on overflow.
// - Only the indirect add-with-carry changes add-skip skip behaviour.
// - Prefix DDh, 0001dddd ANDs immediate into A; two cycles.
// - Byte 39h ANDs memory nibble at pointer pair into A; one cycle.
// - Prefix DCh, 00011rr0 ANDs pair into wide accumulator; two cycles.
// - Prefix DCh, 00010rr0 ANDs wide accumulator into selected pair; two cycles.
// - AND gives one only where both bits are one; source unchanged.
// - Byte 3Eh adds A, memory nibble and carry; sum to A, carry-out to carry.
module asl_exec (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ins_valid,
  input  wire logic [7:0] ins_byte,
  input  wire logic       ins_two_byte,
  input  wire logic [3:0] mem_rdata,
  output logic      [7:0] wide_accumulator,
  output logic      [7:0] pair_0,
  output logic      [7:0] pair_1,
  output logic      [7:0] pair_2,
  output logic      [7:0] pair_3,
  output logic            carry_flag,
  output logic            skip,
  output logic            busy,
  output logic            illegal
);

  typedef struct packed {
    asl_pkg::asl_state_e st;
    asl_pkg::asl_pend_e  pend;
    logic [7:0]          ea;
    logic [3:0][7:0]     pr;
    logic                cy;
    logic                adc_prev;
    logic                adc_cy;
    logic                skip;
    logic                busy;
    logic                ill;
    logic                drop2;
  } asl_exec_s;

  asl_exec_s         s_q;
  asl_exec_s         s_d;
  logic        [7:0] alu_a;
  logic        [7:0] alu_b;
  logic              alu_cin;
  logic              alu_narrow;
  asl_pkg::asl_fn_e  alu_fn;
  logic        [7:0] alu_res;
  logic              alu_cout;
  logic        [1:0] sel;
  logic              is_ads_imm;
  logic              ovf_skip;
  asl_pkg::asl_pend_e pend_eff;

  asl_alu u_alu (
    .opa    (alu_a),
    .opb    (alu_b),
    .cin    (alu_cin),
    .narrow (alu_narrow),
    .fn     (alu_fn),
    .res    (alu_res),
    .cout   (alu_cout)
  );

  // Operand select
  always_comb
  begin
    sel        = ins_byte[2:1];
    is_ads_imm = (ins_byte[7:4] == `ASL_HI_ADS_IMM);
    alu_a      = s_q.ea;
    alu_b      = `ASL_RST_BYTE;
    alu_cin    = 1'b0;
    alu_narrow = 1'b1;
    alu_fn     = asl_pkg::ASL_FN_PASS;
    pend_eff   = s_q.pend;
    // Pair prefix leaves the choice of operation to the second byte
    if (s_q.pend == asl_pkg::ASL_OPN_NONE && !ins_byte[0])
    begin
      case (ins_byte[7:3])
        `ASL_SB_ADS_SRC: pend_eff = asl_pkg::ASL_OPN_ADS_SRC;
        `ASL_SB_ADS_DST: pend_eff = asl_pkg::ASL_OPN_ADS_DST;
        `ASL_SB_AND_SRC: pend_eff = asl_pkg::ASL_OPN_AND_SRC;
        `ASL_SB_AND_DST: pend_eff = asl_pkg::ASL_OPN_AND_DST;
        default:         pend_eff = asl_pkg::ASL_OPN_NONE;
      endcase
    end
    if (s_q.pend == asl_pkg::ASL_OPN_AND_IMM && ins_byte[7:4] != `ASL_HI_AND_IMM)
    begin
      pend_eff = asl_pkg::ASL_OPN_NONE;
    end
    if (s_q.st == asl_pkg::ASL_ST_SECOND)
    begin
      alu_narrow = 1'b0;
      case (pend_eff)
        asl_pkg::ASL_OPN_ADS_WIMM:
        begin
          alu_b  = ins_byte;
          alu_fn = asl_pkg::ASL_FN_ADD;
        end
        asl_pkg::ASL_OPN_ADS_SRC, asl_pkg::ASL_OPN_ADS_DST:
        begin
          alu_b  = s_q.pr[sel];
          alu_fn = asl_pkg::ASL_FN_ADD;
        end
        asl_pkg::ASL_OPN_AND_IMM:
        begin
          alu_narrow = 1'b1;
          alu_b      = {4'h0, ins_byte[3:0]};
          alu_fn     = asl_pkg::ASL_FN_AND;
        end
        asl_pkg::ASL_OPN_AND_SRC, asl_pkg::ASL_OPN_AND_DST:
        begin
          alu_b  = s_q.pr[sel];
          alu_fn = asl_pkg::ASL_FN_AND;
        end
        default:
        begin
          alu_fn = asl_pkg::ASL_FN_PASS;
        end
      endcase
    end
    else
    begin
      alu_a = {4'h0, s_q.ea[3:0]};
      if (is_ads_imm)
      begin
        alu_b  = {4'h0, ins_byte[3:0]};
        alu_fn = asl_pkg::ASL_FN_ADD;
      end
      else if (ins_byte == `ASL_OP_ADS_IND)
      begin
        alu_b  = {4'h0, mem_rdata};
        alu_fn = asl_pkg::ASL_FN_ADD;
      end
      else if (ins_byte == `ASL_OP_ADC_IND)
      begin
        alu_b   = {4'h0, mem_rdata};
        alu_cin = s_q.cy;
        alu_fn  = asl_pkg::ASL_FN_ADC;
      end
      else if (ins_byte == `ASL_OP_AND_IND)
      begin
        alu_b  = {4'h0, mem_rdata};
        alu_fn = asl_pkg::ASL_FN_AND;
      end
    end
  end

  // Sequencer
  always_comb
  begin
    s_d      = s_q;
    s_d.skip = 1'b0;
    ovf_skip = 1'b0;
    if (ins_valid)
    begin
      case (s_q.st)
        asl_pkg::ASL_ST_DROP:
        begin
          // Discard one byte; a two-byte victim costs a second drop
          s_d.adc_prev = 1'b0;
          if (ins_two_byte && !s_q.drop2)
          begin
            s_d.drop2 = 1'b1;
          end
          else
          begin
            s_d.st    = asl_pkg::ASL_ST_FIRST;
            s_d.busy  = 1'b0;
            s_d.drop2 = 1'b0;
          end
        end
        asl_pkg::ASL_ST_SECOND:
        begin
          s_d.st       = asl_pkg::ASL_ST_FIRST;
          s_d.busy     = 1'b0;
          s_d.adc_prev = 1'b0;
          s_d.pend     = asl_pkg::ASL_OPN_NONE;
          case (pend_eff)
            asl_pkg::ASL_OPN_ADS_WIMM, asl_pkg::ASL_OPN_ADS_SRC:
            begin
              s_d.ea   = alu_res;
              ovf_skip = alu_cout;
            end
            asl_pkg::ASL_OPN_ADS_DST:
            begin
              s_d.pr[sel] = alu_res;
              ovf_skip    = alu_cout;
            end
            asl_pkg::ASL_OPN_AND_IMM:
            begin
              s_d.ea[3:0] = alu_res[3:0];
            end
            asl_pkg::ASL_OPN_AND_SRC:
            begin
              s_d.ea = alu_res;
            end
            asl_pkg::ASL_OPN_AND_DST:
            begin
              s_d.pr[sel] = alu_res;
            end
            default:
            begin
              s_d.ill = 1'b1;
            end
          endcase
          if (ovf_skip)
          begin
            s_d.skip = 1'b1;
            s_d.st   = asl_pkg::ASL_ST_DROP;
            s_d.busy = 1'b1;
          end
        end
        default:
        begin
          s_d.adc_prev = 1'b0;
          s_d.ill      = 1'b0;
          if (is_ads_imm && s_q.adc_prev)
          begin
            // Add-skip after indirect add-with-carry: carry skips it, overflow ignored
            if (!s_q.adc_cy)
            begin
              s_d.ea[3:0] = alu_res[3:0];
            end
          end
          else if (is_ads_imm || ins_byte == `ASL_OP_ADS_IND)
          begin
            s_d.ea[3:0] = alu_res[3:0];
            ovf_skip    = alu_cout;
          end
          else if (ins_byte == `ASL_OP_ADC_IND)
          begin
            s_d.ea[3:0]  = alu_res[3:0];
            s_d.cy       = alu_cout;
            s_d.adc_prev = 1'b1;
            s_d.adc_cy   = alu_cout;
          end
          else if (ins_byte == `ASL_OP_AND_IND)
          begin
            s_d.ea[3:0] = alu_res[3:0];
          end
          else
          begin
            s_d.st   = asl_pkg::ASL_ST_SECOND;
            s_d.busy = 1'b1;
            s_d.pend = asl_pkg::ASL_OPN_NONE;
            if (ins_byte == `ASL_OP_ADS_WIDE_IMM)
            begin
              s_d.pend = asl_pkg::ASL_OPN_ADS_WIMM;
            end
            else if (ins_byte == `ASL_OP_PFX_AND_IMM)
            begin
              s_d.pend = asl_pkg::ASL_OPN_AND_IMM;
            end
            else if (ins_byte == `ASL_OP_PFX_PAIR)
            begin
              s_d.pend = asl_pkg::ASL_OPN_NONE;
            end
            else
            begin
              s_d.st   = asl_pkg::ASL_ST_FIRST;
              s_d.busy = 1'b0;
              s_d.ill  = 1'b1;
            end
          end
          if (ovf_skip)
          begin
            s_d.skip = 1'b1;
          end
          if (s_d.skip)
          begin
            s_d.st   = asl_pkg::ASL_ST_DROP;
            s_d.busy = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q.st       <= asl_pkg::ASL_ST_FIRST;
      s_q.pend     <= asl_pkg::ASL_OPN_NONE;
      s_q.ea       <= `ASL_RST_BYTE;
      s_q.pr       <= {4{`ASL_RST_BYTE}};
      s_q.cy       <= 1'b0;
      s_q.adc_prev <= 1'b0;
      s_q.adc_cy   <= 1'b0;
      s_q.skip     <= 1'b0;
      s_q.busy     <= 1'b0;
      s_q.ill      <= 1'b0;
      s_q.drop2    <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wide_accumulator = s_q.ea;
  assign pair_0           = s_q.pr[0];
  assign pair_1           = s_q.pr[1];
  assign pair_2           = s_q.pr[2];
  assign pair_3           = s_q.pr[3];
  assign carry_flag       = s_q.cy;
  assign skip             = s_q.skip;
  assign busy             = s_q.busy;
  assign illegal          = s_q.ill;

endmodule : asl_exec

// *** verif/asl_exec_props.sv ***
`timescale 1ns/1ps
module asl_exec_props (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ins_valid,
  input wire logic [7:0] ins_byte,
  input wire logic       ins_two_byte,
  input wire logic [3:0] mem_rdata,
  input wire logic [7:0] wide_accumulator,
  input wire logic [7:0] pair_0,
  input wire logic [7:0] pair_1,
  input wire logic [7:0] pair_2,
  input wire logic [7:0] pair_3,
  input wire logic       carry_flag,
  input wire logic       skip,
  input wire logic       busy,
  input wire logic       illegal
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] acc;
  assign acc = wide_accumulator[3:0];
  sequence first_s(logic [7:0] b);
    ins_valid && !busy && !skip && ins_byte == b;
  endsequence
  sequence wide_s;
    first_s(8'hC9) ##1 ins_valid;
  endsequence
  sequence adc_ads_s;
    first_s(8'h3E) ##1 ins_valid && ins_byte[7:4] == 4'hA;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0) rst |=> wide_accumulator == 8'h00 && pair_1 == 8'h00
    && !carry_flag && !skip && !busy && !illegal) else $error("state not cleared by reset");
  ads_imm_a: assert property (
    ins_valid && !busy && !skip && ins_byte[7:4] == 4'hA && $past(ins_byte) != 8'h3E |=>
    {skip, acc} == $past({1'b0, acc} + {1'b0, ins_byte[3:0]}) && wide_accumulator[7:4] == $past(wide_accumulator[7:4]))
    else $error("short immediate add wrong");
  ads_wide_a: assert property (
    wide_s |=> {skip, wide_accumulator} == $past({1'b0, wide_accumulator} + {1'b0, ins_byte}))
    else $error("wide immediate add wrong");
  ads_ind_a: assert property (
    first_s(8'h3F) |=> {skip, acc} == $past({1'b0, acc} + {1'b0, mem_rdata})) else $error("indirect add wrong");
  prefix_busy_a: assert property (
    first_s(8'hDC) |=> busy) else $error("prefix not held");
  skip_pulse_a: assert property (
    skip |=> !skip) else $error("skip longer than one cycle");
  carry_hold_a: assert property (
    ins_valid && ins_byte != 8'h3E |=> $stable(carry_flag)) else $error("carry changed");
  adc_skip_a: assert property (
    adc_ads_s ##0 carry_flag |=> acc == $past(acc) && !skip && !busy) else $error("add after carry not skipped");
  adc_inhibit_a: assert property (
    adc_ads_s ##0 !carry_flag |=> !skip && acc == $past(acc + ins_byte[3:0])) else $error("inhibited skip fired");
  and_ind_a: assert property (
    first_s(8'h39) |=> acc == $past(acc & mem_rdata) && !skip) else $error("indirect and wrong");
  adc_ind_a: assert property (
    first_s(8'h3E) |=> {carry_flag, acc} == $past({1'b0, acc} + {1'b0, mem_rdata} + {4'h0, carry_flag}))
    else $error("add with carry wrong");
endmodule : asl_exec_props

bind asl_exec asl_exec_props u_props (.mclk, .rst, .ins_valid, .ins_byte, .ins_two_byte, .mem_rdata,
  .wide_accumulator, .pair_0, .pair_1, .pair_2, .pair_3, .carry_flag, .skip, .busy, .illegal);

// *** verif/asl_exec_tb_top.sv ***
`timescale 1ns/1ps
module asl_exec_tb_top;
  logic       mclk;
  logic       rst;
  logic       ins_valid;
  logic [7:0] ins_byte;
  logic       ins_two_byte;
  logic [3:0] mem_rdata;
  logic [7:0] wide_accumulator;
  logic [7:0] pair_0;
  logic [7:0] pair_1;
  logic [7:0] pair_2;
  logic [7:0] pair_3;
  logic       carry_flag;
  logic       skip;
  logic       busy;
  logic       illegal;
  int         n_mismatch = 0;
  int         comparisons = 0;
  int         cycles = 0;

  asl_exec dut (.mclk, .rst, .ins_valid, .ins_byte, .ins_two_byte, .mem_rdata, .wide_accumulator,
    .pair_0, .pair_1, .pair_2, .pair_3, .carry_flag, .skip, .busy, .illegal);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One byte per cycle; caller is at a falling edge
  task automatic put(input logic [7:0] b, input logic [3:0] m = 4'h0, input logic t = 1'b0);
    ins_valid = 1'b1;
    ins_byte = b;
    mem_rdata = m;
    ins_two_byte = t;
    @(negedge mclk);
  endtask : put

  task automatic idle;
    ins_valid = 1'b0;
    @(negedge mclk);
  endtask : idle

  task automatic t_reset;
    check(wide_accumulator, 8'h00);
    check(pair_0 | pair_1 | pair_2 | pair_3, 8'h00);
    check({4'h0, carry_flag, skip, busy, illegal}, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_dec;
    put(8'hA8);
    put(8'hA6);
    put(8'h3E, 4'h9);
    check(wide_accumulator, 8'h07);
    check({7'h00, carry_flag}, 8'h01);
    put(8'hAA);
    check({6'h00, skip, busy}, 8'h00);
    put(8'hA1);
    check(wide_accumulator, 8'h08);
    put(8'hA1);
    put(8'h3E, 4'h4);
    check({3'h0, carry_flag, wide_accumulator[3:0]}, 8'h0E);
    put(8'hAA);
    check({3'h0, skip, wide_accumulator[3:0]}, 8'h08);
    put(8'hA1);
    check(wide_accumulator, 8'h09);
    idle();
    $display("t_dec done");
  endtask : t_dec

  task automatic t_ind;
    put(8'h3F, 4'h2);
    check({3'h0, skip, wide_accumulator[3:0]}, 8'h0B);
    put(8'hAF);
    check({3'h0, skip, wide_accumulator[3:0]}, 8'h1A);
    put(8'hA5);
    check({3'h0, carry_flag, wide_accumulator[3:0]}, 8'h0A);
    put(8'h39, 4'h6);
    check(wide_accumulator, 8'h02);
    put(8'hDD);
    put(8'h1D);
    check(wide_accumulator, 8'h00);
    put(8'hFF);
    check({illegal, wide_accumulator[6:0]}, 8'h80);
    idle();
    $display("t_ind done");
  endtask : t_ind

  task automatic t_wide;
    put(8'hC9);
    check({7'h00, busy}, 8'h01);
    put(8'hF0);
    put(8'hC9);
    put(8'h20);
    check({3'h0, skip, wide_accumulator[7:4]}, 8'h11);
    put(8'hC9, 4'h0, 1'b1);
    put(8'h55, 4'h0, 1'b1);
    check(wide_accumulator, 8'h10);
    put(8'hDC);
    put(8'h92);
    check(pair_1, 8'h10);
    put(8'hDC);
    put(8'h96);
    put(8'hDC);
    put(8'h9A);
    check(wide_accumulator, 8'h20);
    put(8'hDC);
    put(8'h96);
    check(pair_3, 8'h30);
    put(8'hDC);
    put(8'h16);
    check(pair_3, 8'h20);
    put(8'hDC);
    put(8'h1A);
    check(wide_accumulator, 8'h00);
    check(pair_1, 8'h10);
    check(pair_0 | pair_2, 8'h00);
    idle();
    $display("t_wide done");
  endtask : t_wide

  initial
  begin
    rst = 1'b1;
    ins_valid = 1'b0;
    ins_byte = 8'h00;
    ins_two_byte = 1'b0;
    mem_rdata = 4'h0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_dec();
    t_ind();
    t_wide();
    stop_test();
  end
endmodule : asl_exec_tb_top
